// *** src/wbt_defs.svh ***
// Purpose: offsets, field positions, reset values and timing for the
//          wake bank select and cyclic timer control block
// Assumes: 200 MHz clock, word-wide register bus
// Notes:   timer counts are in 100 us ticks of the prescaler
//
// Overview of operation
// R1 - bank select picks wake module, codes 5-7 reserved
// R2 - pull field reserved while bank five selected
// R3 - sync filter only when input four is sync
// R4 - software keeps sync on-time at least 100 us
// R5 - restart clears bits 14,8,7,4 and bank
// R6 - pin two select reachable only in bank two
// R7 - sync function reachable only through bank four
// R8 - software assigns filter timer to a switch
// R9 - fail-safe entry forces enables to 01, exceptions
// R10 - fail-safe uses 16 us static filter
// R11 - second timer on-time eight-code decode
// R12 - second timer period decode 10 ms to 2 s
// R13 - first timer on-time same decode
// R14 - first timer period same decode
// R15 - cyclic wake source select decode
// R16 - timer register reserved bits read zero
// R17 - reset and restart clear timer register
// R18 - assigned timer starts on running on-time write
// R19 - restart switch clear also clears timer
// R20 - sensing and wake run together
// R21 - timing counted from prescaled oscillator ticks
`ifndef WBT_DEFS_SVH
`define WBT_DEFS_SVH

// register indices, byte address is four times the index
`define WBT_IDX_WAKE_CTRL    8'h05
`define WBT_IDX_TIMER_CTRL   8'h06
`define WBT_IDX_STATUS       8'h10

// reset values
`define WBT_WAKE_CTRL_RST    16'h0020
`define WBT_TIMER_CTRL_RST   16'h0000
`define WBT_WAKE_EN_RST      2'h1
`define WBT_WAKE_EN_FS       2'h1

// codes
`define WBT_BANK_LAST        3'h4
`define WBT_BANK_TWO         3'h1
`define WBT_BANK_FOUR        3'h3
`define WBT_BANK_FIVE        3'h4
`define WBT_EN_SYNC          2'h2
`define WBT_FILT_16US        3'h0
`define WBT_FILT_SYNC        3'h4
`define WBT_ON_STOP_HIGH     3'h6

// restart keeps all wake control bits outside this mask
`define WBT_WAKE_RESTART_CLR 16'h4197

// timing
`define WBT_CLK_PERIOD_NS    5
`define WBT_TICK_NS          100000
`define WBT_MIN_SYNC_ON_US   100

`endif

// *** src/wbt_pkg.sv ***
// Purpose: types for the wake bank select and cyclic timer block
// Assumes: nothing beyond the defines header
// Notes:   struct layouts follow the register bit order
`default_nettype none

package wbt_pkg;

    // per-bank wake configuration, held once for each wake module
    typedef struct packed {
        logic [2:0] filter;
        logic [1:0] pull;
        logic [1:0] enable;
    } wbt_wake_cfg_t;

    // timer control register, msb first
    typedef struct packed {
        logic [2:0] on2;
        logic       res12;
        logic [2:0] per2;
        logic [1:0] cyc;
        logic [2:0] on1;
        logic       res3;
        logic [2:0] per1;
    } wbt_timer_reg_t;

    // captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } wbt_bus_req_t;

endpackage

`default_nettype wire

// *** src/wbt_ctrl.sv ***
// Purpose: wake bank select, wake control register and two cyclic timers
// Assumes: AHB-Lite single word transfers, one slave on the bus
// Notes:   restart and fail-safe events come from logic on this clock
`default_nettype none
`include "wbt_defs.svh"

module wbt_ctrl #(
    parameter int TICK_CYCLES = `WBT_TICK_NS / `WBT_CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // device events
    input  wire logic        restart,
    input  wire logic        fail_safe_entry,
    input  wire logic        fail_safe_mode,
    input  wire logic [1:0]  hs_timer_assign,
    // effective wake and timer outputs
    output logic      [14:0] wake_filter_eff,
    output logic      [9:0]  wake_pull_eff,
    output logic      [9:0]  wake_enable_eff,
    output logic             pin_two_wake,
    output logic             sync_input_active,
    output logic      [1:0]  timer_out,
    output logic      [1:0]  cyc_wake_evt
);

    // ********************************************************
    //  decode functions
    // ********************************************************

    // on-time in 100 us ticks; zero means not running
    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        unique case (code)
            3'h1:    on_ticks = 15'h0001;
            3'h2:    on_ticks = 15'h0003;
            3'h3:    on_ticks = 15'h000A;
            3'h4:    on_ticks = 15'h0064;
            3'h5:    on_ticks = 15'h00C8;
            default: on_ticks = 15'h0000;
        endcase
    endfunction

    // period in 100 us ticks
    function automatic logic [14:0] per_ticks(input logic [2:0] code);
        unique case (code)
            3'h0: per_ticks = 15'h0064;
            3'h1: per_ticks = 15'h00C8;
            3'h2: per_ticks = 15'h01F4;
            3'h3: per_ticks = 15'h03E8;
            3'h4: per_ticks = 15'h07D0;
            3'h5: per_ticks = 15'h1388;
            3'h6: per_ticks = 15'h2710;
            3'h7: per_ticks = 15'h4E20;
        endcase
    endfunction

    // ********************************************************
    //  bus slave
    // ********************************************************

    wbt_pkg::wbt_bus_req_t req;
    logic                  rd_wait;
    wire                   take = hsel & htrans[1] & hready;
    wire                   wr_now = req.valid & req.write;
    wire                   wr_wake = wr_now &
                                     (req.index == `WBT_IDX_WAKE_CTRL);
    wire                   wr_timer = wr_now &
                                      (req.index == `WBT_IDX_TIMER_CTRL);

    // address phase capture; reads get one wait state so that a
    // write in the preceding data phase is already visible
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req       <= '0;
            rd_wait   <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            req.valid <= take;
            req.write <= hwrite;
            req.index <= haddr[9:2];
            rd_wait   <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
        end
    end

    // ********************************************************
    //  wake control storage
    // ********************************************************

    wbt_pkg::wbt_wake_cfg_t cfg [5];
    logic [2:0]             bank;
    logic                   pin_two;
    wire  [15:0]            wd = hwdata[15:0];
    wbt_pkg::wbt_wake_cfg_t cur;
    assign cur = cfg[bank];

    wire sync_on  = cfg[3].enable == `WBT_EN_SYNC;     // [R7]
    wire bank_ok  = wd[2:0] <= `WBT_BANK_LAST;        // [R1]
    wire filt_ok  = (wd[13:11] < `WBT_FILT_SYNC) |
                    ((wd[13:11] == `WBT_FILT_SYNC) & sync_on); // [R3]
    wire pull_ok  = bank != `WBT_BANK_FIVE;           // [R2]
    wire pin2_ok  = bank == `WBT_BANK_TWO;            // [R6]

    // field writes address the bank selected before this write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int b = 0; b < 5; b++) begin
                cfg[b] <= '{filter: 3'h0, pull: 2'h0,
                            enable: `WBT_WAKE_EN_RST};
            end
            bank    <= 3'h0;
            pin_two <= 1'b0;
        end else begin
            if (wr_wake) begin
                if (bank_ok)
                    bank <= wd[2:0];
                if (pin2_ok)
                    pin_two <= wd[15];
                if (filt_ok)
                    cfg[bank].filter <= wd[13:11];
                if (pull_ok)
                    cfg[bank].pull <= wd[10:9];
                cfg[bank].enable <= wd[6:5];
            end
            if (fail_safe_entry) begin
                for (int b = 0; b < 5; b++) begin
                    if (!(b == 1 && !pin_two) &&
                        !(b == 3 && sync_on))
                        cfg[b].enable <= `WBT_WAKE_EN_FS; // [R9]
                end
            end
            if (restart)
                bank <= 3'h0;                         // [R5]
        end
    end

    wire [15:0] wake_view = {pin_two & pin2_ok, 1'b0, cur.filter,
                             pull_ok ? cur.pull : 2'h0, 2'h0,
                             cur.enable, 2'h0, bank};

    // ********************************************************
    //  timer control register
    // ********************************************************

    wbt_pkg::wbt_timer_reg_t tmr;
    wbt_pkg::wbt_timer_reg_t tmr_wr;
    assign tmr_wr = wbt_pkg::wbt_timer_reg_t'(wd & 16'hEFF7); // [R16]

    // restart wipes the register, which also covers the case where
    // a cyclic sensing switch is cleared during restart
    always_ff @(posedge clk) begin
        if (!rst_n)
            tmr <= wbt_pkg::wbt_timer_reg_t'(`WBT_TIMER_CTRL_RST); // [R17]
        else if (restart)
            tmr <= wbt_pkg::wbt_timer_reg_t'(`WBT_TIMER_CTRL_RST); // [R19]
        else if (wr_timer)
            tmr <= tmr_wr;
    end

    // ********************************************************
    //  prescaler
    // ********************************************************

    logic [15:0] pre_cnt;
    logic        tick;

    // one pulse per 100 us of oscillator time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else begin
            tick    <= pre_cnt == 16'(TICK_CYCLES - 1);   // [R21]
            pre_cnt <= (pre_cnt == 16'(TICK_CYCLES - 1)) ?
                       16'h0000 : pre_cnt + 16'h0001;
        end
    end

    // ********************************************************
    //  cyclic timers
    // ********************************************************

    wire [2:0] on_code [2];
    wire [2:0] per_code [2];
    assign on_code[0]  = tmr.on1;                        // [R13]
    assign on_code[1]  = tmr.on2;                        // [R11]
    assign per_code[0] = tmr.per1;                       // [R14]
    assign per_code[1] = tmr.per2;                       // [R12]

    logic [14:0] cnt [2];
    wire  [1:0]  wake_sel;
    wire  [1:0]  run;
    wire  [1:0]  restart_cnt;
    assign wake_sel = {tmr.cyc == 2'h2, tmr.cyc == 2'h1}; // [R15]

    for (genvar t = 0; t < 2; t++) begin : g_tmr
        wire [14:0] on_t  = on_ticks(on_code[t]);
        wire [14:0] per_t = per_ticks(per_code[t]);
        wire        wr_on = wr_timer &
                            (t == 0 ? tmr_wr.on1 != tmr.on1
                                    : tmr_wr.on2 != tmr.on2);
        // runs only once assigned to sensing or wake
        assign run[t] = (on_t != 15'h0000) &
                        (hs_timer_assign[t] | wake_sel[t]); // [R18]
        assign restart_cnt[t] = wr_on | ~run[t];
        // >= so a shortened period restarts instead of wrapping
        wire        last  = cnt[t] >= per_t - 15'h0001;
        wire        on_end = tick & run[t] & (cnt[t] == on_t - 15'h0001);

        // phase counter restarts whenever a new on-time is written
        always_ff @(posedge clk) begin
            if (!rst_n)
                cnt[t] <= 15'h0000;
            else if (restart_cnt[t])
                cnt[t] <= 15'h0000;                      // [R18]
            else if (tick)
                cnt[t] <= last ? 15'h0000 : cnt[t] + 15'h0001;
        end

        // output level and wake pulse; wake does not stop sensing
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                timer_out[t]    <= 1'b0;
                cyc_wake_evt[t] <= 1'b0;
            end else begin
                if (on_code[t] >= `WBT_ON_STOP_HIGH)
                    timer_out[t] <= 1'b1;                // [R11]
                else
                    timer_out[t] <= run[t] & (cnt[t] < on_t);
                cyc_wake_evt[t] <= on_end & wake_sel[t]; // [R20]
            end
        end
    end

    // ********************************************************
    //  read data and effective outputs
    // ********************************************************

    wire [15:0] status_view = {10'h000, sync_on, pin_two,
                               run, timer_out};
    wire [15:0] rd_mux =
        (req.index == `WBT_IDX_WAKE_CTRL)  ? wake_view :
        (req.index == `WBT_IDX_TIMER_CTRL) ? 16'(tmr) :
        (req.index == `WBT_IDX_STATUS)     ? status_view : 16'h0000;

    // read data loaded in the wait cycle; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (rd_wait)
            hrdata <= {16'h0000, rd_mux};
    end

    // fail-safe forces static 16 us filtering on every input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_filter_eff   <= '0;
            wake_pull_eff     <= '0;
            wake_enable_eff   <= '0;
            pin_two_wake      <= 1'b0;
            sync_input_active <= 1'b0;
        end else begin
            for (int b = 0; b < 5; b++) begin
                wake_filter_eff[3*b +: 3] <= fail_safe_mode ?
                    `WBT_FILT_16US : cfg[b].filter;       // [R10]
                wake_pull_eff[2*b +: 2]   <= cfg[b].pull;
                wake_enable_eff[2*b +: 2] <= cfg[b].enable;
            end
            pin_two_wake      <= pin_two;
            sync_input_active <= sync_on;
        end
    end

    // ********************************************************
    //  assertions
    // ********************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    bank_range_a: assert property (bank <= `WBT_BANK_LAST) // [R1]
        else $error("bank select left legal range");

    pull_five_a: assert property (                          // [R2]
        wr_wake && bank == `WBT_BANK_FIVE && !restart
        |=> $stable(cfg[4].pull))
        else $error("pull changed while bank five selected");

    sync_filter_a: assert property (                        // [R3]
        wr_wake && wd[13:11] == `WBT_FILT_SYNC && !sync_on
        |=> cfg[$past(bank)].filter != `WBT_FILT_SYNC ||
            $past(cur.filter) == `WBT_FILT_SYNC)
        else $error("sync filter accepted without sync input");

    restart_bank_a: assert property (restart |=> bank == 3'h0) // [R5]
        else $error("restart did not clear bank select");

    fs_enable_a: assert property (                          // [R9]
        fail_safe_entry |=> cfg[0].enable == `WBT_WAKE_EN_FS &&
                            cfg[4].enable == `WBT_WAKE_EN_FS)
        else $error("fail-safe entry did not force enable");

    fs_filter_a: assert property (                          // [R10]
        fail_safe_mode |=> wake_filter_eff == 15'h0000)
        else $error("filter not forced during fail-safe");

    stop_low_a: assert property (                           // [R13]
        tmr.on1 == 3'h0 ##1 tmr.on1 == 3'h0 |-> !timer_out[0])
        else $error("stopped timer output not low");

    resv_zero_a: assert property (!tmr.res12 && !tmr.res3) // [R16]
        else $error("reserved timer bits not zero");

    restart_tmr_a: assert property (restart |=> tmr == '0) // [R17]
        else $error("restart left timer settings");

    read_wait_a: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");

    write_wait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write answer not without wait state");

    resp_okay_a: assert property (!hresp)
        else $error("error response on the bus");

    pin_two_bank_a: assert property (                       // [R6]
        wr_wake && bank != `WBT_BANK_TWO |=> $stable(pin_two))
        else $error("pin two bit changed outside bank two");

    sync_bank_a: assert property (                          // [R7]
        wr_wake && bank != `WBT_BANK_FOUR && !fail_safe_entry
        |=> $stable(cfg[3].enable))
        else $error("input four enable changed from another bank");

    fs_keep_two_a: assert property (                        // [R9]
        fail_safe_entry && !pin_two && !wr_wake
        |=> $stable(cfg[1].enable))
        else $error("fail-safe entry forced fail output enable");

    stop_high_a: assert property (                          // [R11]
        tmr.on2 >= `WBT_ON_STOP_HIGH |=> timer_out[1])
        else $error("stopped high timer output not high");

    stop_low_two_a: assert property (                       // [R11]
        tmr.on2 == 3'h0 |=> !timer_out[1])
        else $error("stopped low timer output not low");

    wake_one_a: assert property (                           // [R15]
        tmr.cyc != 2'h1 |=> !cyc_wake_evt[0])
        else $error("first timer woke while not selected");

    wake_two_a: assert property (                           // [R15]
        tmr.cyc != 2'h2 |=> !cyc_wake_evt[1])
        else $error("second timer woke while not selected");

    unassigned_timer_a: assert property (                   // [R18]
        !hs_timer_assign[0] && tmr.cyc != 2'h1 &&
        tmr.on1 < `WBT_ON_STOP_HIGH |=> !timer_out[0])
        else $error("unassigned timer ran");

    wake_sense_a: assert property (                         // [R20]
        (cyc_wake_evt & ~timer_out) == 2'h0)
        else $error("wake pulse stopped cyclic sensing");

endmodule // wbt_ctrl

`default_nettype wire

// *** verif/wake_bank_cyclic_timer_ctrl_tb_top.sv ***
// Purpose: self-checking bench for the wake bank and cyclic timer block
// Assumes: short prescaler so that the longest periods stay affordable
// Notes:   random timer writes come from a fixed seed
`default_nettype none
`include "wbt_defs.svh"

module wake_bank_cyclic_timer_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // two clocks per tick keeps a 1 s period at 20000 cycles
    localparam int         T          = 2;
    localparam int         ON_T [8]   = '{0, 1, 3, 10, 100, 200, 0, 0};
    localparam int         PER_T [8]  = '{100, 200, 500, 1000, 2000, 5000,
                                          10000, 20000};
    localparam logic [7:0] WK         = `WBT_IDX_WAKE_CTRL;
    localparam logic [7:0] TM         = `WBT_IDX_TIMER_CTRL;

    logic        clk          = 1'b0;
    logic        rst_n        = 1'b0;
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [31:0] hwdata       = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        restart      = 1'b0;
    logic        fs_entry     = 1'b0;
    logic        fs_mode      = 1'b0;
    logic [1:0]  hs_assign    = 2'h0;
    logic [14:0] filt_eff;
    logic [9:0]  pull_eff;
    logic [9:0]  en_eff;
    logic        pin_two_wake;
    logic        sync_act;
    logic [1:0]  timer_out;
    logic [1:0]  cyc_wake_evt;
    int          fails        = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    always #2.5 clk = ~clk;

    wbt_ctrl #(.TICK_CYCLES(T)) i_wbt_ctrl (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .restart(restart), .fail_safe_entry(fs_entry),
        .fail_safe_mode(fs_mode), .hs_timer_assign(hs_assign),
        .wake_filter_eff(filt_eff), .wake_pull_eff(pull_eff),
        .wake_enable_eff(en_eff), .pin_two_wake(pin_two_wake),
        .sync_input_active(sync_act), .timer_out(timer_out),
        .cyc_wake_evt(cyc_wake_evt)
    );

    // ********************************
    // checking and reporting
    // ********************************
    task automatic complete_run();
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // hang guard, well above the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            fails++;
            complete_run();
        end
    end

    // ********************************
    // bus and stimulus helpers
    // ********************************
    // one single transfer; always entered just after a rising edge;
    // waits end only on hready, the hang guard bounds them
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [15:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        do
            @(posedge clk);
        while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'($urandom()), wd};
        do
            @(posedge clk);
        while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [15:0] e);
        logic [31:0] x;
        bus(1'b0, idx, 16'h0, x);
        chk_val(x, {16'h0, e});
    endtask

    // one-cycle event: 0 restart, 1 fail-safe entry; lets effects settle
    task automatic pulse(input int which);
        if (which == 0) restart <= 1'b1;
        else fs_entry <= 1'b1;
        @(posedge clk);
        restart  <= 1'b0;
        fs_entry <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    function automatic logic [15:0] tv(input logic [2:0] on2,
        input logic [2:0] per2, input logic [1:0] cyc,
        input logic [2:0] on1, input logic [2:0] per1);
        return {on2, 1'b0, per2, cyc, on1, 1'b0, per1};
    endfunction

    // first on-phase may be cut short by the restart, so skip it;
    // wake pulses counted in a window shifted 3 cycles past each fall
    task automatic measure(input int b, output int hi, output int per,
                           output int ev);
        int n;
        n = 0; hi = 0; per = 0; ev = 0;
        while (timer_out[b] !== 1'b1 && n < 60000) begin
            @(posedge clk); n++;
        end
        while (timer_out[b] === 1'b1 && n < 60000) begin
            @(posedge clk); n++;
        end
        while (timer_out[b] !== 1'b1 && per < 60000) begin
            @(posedge clk); per++;
            if (per > 3) ev += int'(cyc_wake_evt[b] === 1'b1);
        end
        while (timer_out[b] === 1'b1 && hi < 60000) begin
            @(posedge clk); hi++;
            ev += int'(cyc_wake_evt[b] === 1'b1);
        end
        repeat (3) begin
            @(posedge clk);
            ev += int'(cyc_wake_evt[b] === 1'b1);
        end
        per += hi;
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        int          hi, per, ev;
        logic [15:0] r;
        int          stops [3] = '{6, 7, 0};
        void'($urandom(93882));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(WK, 16'h0020);
        rd(TM, 16'h0000);
        // every bank code, reserved ones keep the bank
        for (int b = 0; b < 8; b++) begin
            wr(WK, 16'h0020 | 16'(b));
            rd(WK, 16'h0020 | 16'(b < 5 ? b : 4));
        end
        wr(WK, 16'h0424);
        rd(WK, 16'h0024);
        chk_val(32'(pull_eff[9:8]), 32'h0);
        wr(WK, 16'h0021);
        wr(WK, 16'h8001);
        rd(WK, 16'h8001);
        chk_val(32'(pin_two_wake), 32'h1);
        wr(WK, 16'h0003);
        rd(WK, 16'h0023);
        chk_val(32'(pin_two_wake), 32'h0);
        // sync filter refused until input four is sync
        wr(WK, 16'h2043);
        rd(WK, 16'h0043);
        wr(WK, 16'h2040);
        wr(WK, 16'h0003);
        rd(WK, 16'h2043);
        chk_val(32'(sync_act), 32'h1);
        chk_val(32'(filt_eff[11:9]), 32'h4);
        wr(WK, 16'h2040);
        rd(WK, 16'h0000);
        // fail-safe: pin two as fail output and sync input keep enables
        fs_mode <= 1'b1;
        pulse(1);
        chk_val(32'(en_eff), 32'h191);
        chk_val(32'(filt_eff), 32'h0);
        rd(WK, 16'h0020);
        fs_mode <= 1'b0;
        // restart drops bank and timers, keeps per-bank fields
        wr(TM, tv(3'h1, 3'h2, 2'h1, 3'h2, 3'h5));
        wr(WK, 16'h0023);
        pulse(0);
        rd(WK, 16'h0020);
        rd(TM, 16'h0000);
        wr(WK, 16'h0023);
        rd(WK, 16'h2043);
        // timer-one filter in bank four, that timer given to a switch
        hs_assign <= 2'h1;
        wr(WK, 16'h1043);
        rd(WK, 16'h1043);
        chk_val(32'(filt_eff[11:9]), 32'h2);
        wr(8'h30, 16'hFFFF);
        rd(8'h30, 16'h0000);
        // random timer words, reserved cyclic code avoided
        for (int i = 0; i < 12; i++) begin
            r = 16'($urandom());
            if (r[8:7] == 2'h3) r[8] = 1'b0;
            hs_assign <= 2'($urandom());
            wr(TM, r);
            rd(TM, r & 16'hEFF7);
        end
        // a running code on an unassigned timer keeps it idle
        hs_assign <= 2'h0;
        wr(TM, tv(3'h1, 3'h0, 2'h0, 3'h1, 3'h0));
        repeat (3) @(posedge clk);
        chk_val(32'(timer_out), 32'h0);
        hs_assign <= 2'h3;
        for (int i = 0; i < 3; i++) begin
            wr(TM, tv(3'(stops[i]), 3'h0, 2'h0, 3'(stops[i]), 3'h0));
            repeat (3) @(posedge clk);
            chk_val(32'(timer_out), stops[i] != 0 ? 32'h3 : 32'h0);
        end
        // first timer: every running on-time, sensing only
        hs_assign <= 2'h1;
        for (int k = 1; k < 6; k++) begin
            wr(TM, 16'h0);
            wr(TM, tv(3'h0, 3'h0, 2'h0, 3'(k), 3'(k - 1)));
            measure(0, hi, per, ev);
            chk_cnt(hi, ON_T[k] * T);
            chk_cnt(per, PER_T[k - 1] * T);
            chk_cnt(ev, 0);
        end
        // second timer: periods with sensing and wake together
        hs_assign <= 2'h2;
        for (int p = 0; p < 7; p++) begin
            wr(TM, 16'h0);
            wr(TM, tv(3'h1, 3'(p), 2'h2, 3'h0, 3'h0));
            measure(1, hi, per, ev);
            chk_cnt(hi, T);
            chk_cnt(per, PER_T[p] * T);
            chk_cnt(ev, 1);
        end
        complete_run();
    end

endmodule // wake_bank_cyclic_timer_ctrl_tb_top

`default_nettype wire
